// File: common/servo_status_pkg.sv
/*
  Constants, register map and carrier types for the servo remote status outputs.
  Assumes a single 40 MHz control clock and a 32-bit Avalon-MM register master.
*/
package servo_status_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] INPOS_RANGE_OFS = 8'h04;
  localparam logic [7:0] ROUGH_RANGE_OFS = 8'h08;
  localparam logic [7:0] FLAGS_OFS = 8'h0c;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_ABS_EN_BIT = 0;
  localparam int CTRL_STATION_DIR_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [15:0] INPOS_RANGE_RESET = 16'h0064;
  localparam logic [15:0] ROUGH_RANGE_RESET = 16'h0000;
  localparam logic [5:0] IRQ_MASK_RESET = 6'h00;
  localparam int FLAG_W = 6;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Flag layout: ready at bit 0 up to brake at bit 5, one layout for any station count
  typedef struct packed {
    logic brake_interlock_out;
    logic torque_limiting_flag;
    logic home_return_done_flag;
    logic rough_match_flag;
    logic in_position_flag;
    logic drive_ready_flag;
  } status_flags_t;

  typedef struct packed {
    logic servo_on_cmd;
    logic forced_stop_in;
    logic alarm_reset_cmd_a;
    logic alarm_reset_cmd_b;
    logic fwd_stroke_end_in;
    logic rev_stroke_end_in;
  } remote_in_t;

  typedef enum logic [1:0] {HR_NONE, HR_RUNNING, HR_VALID} home_state_t;

endpackage

// File: core/servo_remote_status.sv
/*
  Servo remote status outputs: ready, in-position, rough match, home-return done,
  torque limiting and brake interlock, mirrored to fieldbus bits and connector pins,
  with an Avalon-MM register slave and a maskable interrupt.
  Assumes remote inputs arrive asynchronously; motion quantities come from logic on mclk.
*/
`timescale 1ns/10ps
module servo_remote_status #(
  parameter int DROOP_W = 24,
  parameter int RANGE_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Remote inputs from the fieldbus and connector
  input wire servo_status_pkg::remote_in_t remote_in,
  // Drive state on mclk
  input wire logic drive_operable,
  input wire logic alarm_active,
  input wire logic signed [DROOP_W-1:0] droop_count,
  input wire logic signed [DROOP_W-1:0] remaining_dist,
  input wire logic torque_at_limit,
  input wire logic home_busy,
  input wire logic home_done_pulse,
  input wire logic abs_position_erase_alarm,
  input wire logic abs_counter_warning,
  input wire logic gear_change_pulse,
  // Status outputs
  output servo_status_pkg::status_flags_t remote_out,
  output servo_status_pkg::status_flags_t external_io_connector,
  output logic irq,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    servo_status_pkg::remote_in_t sync1;
    servo_status_pkg::remote_in_t sync2;
    logic son_prev;
    logic abs_prev;
    logic dir_prev;
    logic abs_enable;
    logic station_direction_param;
    logic [RANGE_W-1:0] in_position_range_param;
    logic [RANGE_W-1:0] rough_range;
    servo_status_pkg::home_state_t hr;
    servo_status_pkg::status_flags_t flags;
    servo_status_pkg::status_flags_t conn;
    logic [servo_status_pkg::FLAG_W-1:0] irq_sts;
    logic [servo_status_pkg::FLAG_W-1:0] irq_msk;
    logic irq;
    logic [31:0] rdata;
    logic wait_n;
  } state_t;

  state_t st_reg;
  state_t st_next;

  function automatic logic [DROOP_W-1:0] mag(input logic signed [DROOP_W-1:0] v);
    mag = v[DROOP_W-1] ? DROOP_W'(-v) : DROOP_W'(v);
  endfunction

  // ----------------------------------------------------------------
  // Condition decode
  // ----------------------------------------------------------------
  logic son_rise;
  logic hr_clear;
  logic hr_invalidate;
  logic ready_c;
  logic bus_req;
  servo_status_pkg::status_flags_t flags_c;
  assign son_rise = st_reg.sync2.servo_on_cmd & ~st_reg.son_prev;
  assign ready_c = st_reg.sync2.servo_on_cmd & drive_operable & ~alarm_active;
  assign bus_req = avs_read | avs_write;
  assign hr_clear = ~st_reg.sync2.servo_on_cmd | ~st_reg.sync2.forced_stop_in | st_reg.sync2.alarm_reset_cmd_a
    | st_reg.sync2.alarm_reset_cmd_b | alarm_active | ~st_reg.sync2.fwd_stroke_end_in
    | ~st_reg.sync2.rev_stroke_end_in;
  assign hr_invalidate = abs_position_erase_alarm | abs_counter_warning | gear_change_pulse
    | (st_reg.abs_enable & ~st_reg.abs_prev) | (st_reg.station_direction_param ^ st_reg.dir_prev);

  always_comb
  begin
    st_next = st_reg;
    flags_c = st_reg.flags;
    st_next.sync1 = remote_in;
    st_next.sync2 = st_reg.sync1;
    st_next.son_prev = st_reg.sync2.servo_on_cmd;
    st_next.abs_prev = st_reg.abs_enable;
    st_next.dir_prev = st_reg.station_direction_param;

    // Home return tracking; reset state means no return since power-up
    if (hr_invalidate)
      st_next.hr = servo_status_pkg::HR_NONE;
    else if (home_done_pulse)
      st_next.hr = servo_status_pkg::HR_VALID;
    else if (home_busy)
      st_next.hr = servo_status_pkg::HR_RUNNING;

    flags_c.drive_ready_flag = ready_c;
    flags_c.in_position_flag = (mag(droop_count) <= DROOP_W'(st_reg.in_position_range_param)) | son_rise;
    flags_c.rough_match_flag = (mag(remaining_dist) < DROOP_W'(st_reg.rough_range)) | son_rise;
    if (st_reg.abs_enable)
      flags_c.home_return_done_flag = (st_next.hr == servo_status_pkg::HR_VALID) & ~home_busy & ~hr_clear & ready_c;
    else
      flags_c.home_return_done_flag = (st_next.hr == servo_status_pkg::HR_VALID) & ~home_busy;
    flags_c.torque_limiting_flag = torque_at_limit;
    // brake drops on alarm regardless of base circuit
    flags_c.brake_interlock_out = st_reg.sync2.servo_on_cmd & ~alarm_active;
    st_next.flags = flags_c;
    st_next.conn = flags_c;

    // Register slave: data set up on the first edge, commit on the edge the master sees low
    st_next.wait_n = 1'b0;
    if (bus_req & ~st_reg.wait_n)
    begin
      st_next.wait_n = 1'b1;
      st_next.rdata = 32'h0;
      if (avs_read)
      begin
        unique case (avs_address)
          servo_status_pkg::CTRL_OFS:
            st_next.rdata = {30'h0, st_reg.station_direction_param, st_reg.abs_enable};
          servo_status_pkg::INPOS_RANGE_OFS:
            st_next.rdata = 32'(st_reg.in_position_range_param);
          servo_status_pkg::ROUGH_RANGE_OFS:
            st_next.rdata = 32'(st_reg.rough_range);
          servo_status_pkg::FLAGS_OFS:
            st_next.rdata = {26'h0, st_reg.flags};
          servo_status_pkg::IRQ_STATUS_OFS:
            st_next.rdata = {26'h0, st_reg.irq_sts};
          servo_status_pkg::IRQ_MASK_OFS:
            st_next.rdata = {26'h0, st_reg.irq_msk};
          default:
            st_next.rdata = 32'h0;
        endcase
      end
    end

    // Sticky events: rising edge of each flag; set wins over a same-cycle clear
    if (avs_write & st_reg.wait_n)
    begin
      unique case (avs_address)
        servo_status_pkg::CTRL_OFS:
        begin
          st_next.abs_enable = avs_writedata[servo_status_pkg::CTRL_ABS_EN_BIT];
          st_next.station_direction_param = avs_writedata[servo_status_pkg::CTRL_STATION_DIR_BIT];
        end
        servo_status_pkg::INPOS_RANGE_OFS:
          st_next.in_position_range_param = avs_writedata[RANGE_W-1:0];
        servo_status_pkg::ROUGH_RANGE_OFS:
          st_next.rough_range = avs_writedata[RANGE_W-1:0];
        servo_status_pkg::IRQ_STATUS_OFS:
          st_next.irq_sts = st_reg.irq_sts & ~avs_writedata[servo_status_pkg::FLAG_W-1:0];
        servo_status_pkg::IRQ_MASK_OFS:
          st_next.irq_msk = avs_writedata[servo_status_pkg::FLAG_W-1:0];
        default:
          st_next.irq_msk = st_reg.irq_msk;
      endcase
    end
    st_next.irq_sts = st_next.irq_sts | (flags_c & ~st_reg.flags);
    st_next.irq = |(st_reg.irq_sts & st_reg.irq_msk);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.abs_enable <= servo_status_pkg::CTRL_RESET[servo_status_pkg::CTRL_ABS_EN_BIT];
      st_reg.station_direction_param <= servo_status_pkg::CTRL_RESET[servo_status_pkg::CTRL_STATION_DIR_BIT];
      st_reg.in_position_range_param <= RANGE_W'(servo_status_pkg::INPOS_RANGE_RESET);
      st_reg.rough_range <= RANGE_W'(servo_status_pkg::ROUGH_RANGE_RESET);
      st_reg.irq_msk <= servo_status_pkg::IRQ_MASK_RESET;
      st_reg.hr <= servo_status_pkg::HR_NONE;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Waitrequest idles high so no access completes before the slave has looked at it
  assign remote_out = st_reg.flags;
  assign external_io_connector = st_reg.conn;
  assign irq = st_reg.irq;
  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = ~st_reg.wait_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_ready_needs_son: assert property (remote_out.drive_ready_flag |-> $past(remote_in.servo_on_cmd, 3))
    else $error("ready high without servo-on");
  a_inpos_window: assert property ((mag(droop_count) <= DROOP_W'(st_reg.in_position_range_param))
    |=> remote_out.in_position_flag)
    else $error("in-position low inside window");
  a_son_forces: assert property (son_rise |=> remote_out.in_position_flag && remote_out.rough_match_flag)
    else $error("servo-on did not force in-position and rough match");
  a_rough_outside: assert property (!son_rise && (mag(remaining_dist) >= DROOP_W'(st_reg.rough_range))
    |=> !remote_out.rough_match_flag)
    else $error("rough match high outside range");
  a_home_cleared: assert property (st_reg.abs_enable && hr_clear |=> !remote_out.home_return_done_flag)
    else $error("home done high during clearing condition");
  a_home_homing: assert property (home_busy || hr_invalidate |=> !remote_out.home_return_done_flag)
    else $error("home done high while homing or invalidated");
  a_home_is_ready: assert property (st_reg.abs_enable && !hr_clear && !home_busy && !hr_invalidate
    && !home_done_pulse && st_reg.hr == servo_status_pkg::HR_VALID
    |=> remote_out.home_return_done_flag == remote_out.drive_ready_flag)
    else $error("home done differs from ready");
  a_torque_level: assert property (torque_at_limit |=> remote_out.torque_limiting_flag)
    else $error("torque flag missed");
  a_brake_alarm: assert property (alarm_active |=> !remote_out.brake_interlock_out)
    else $error("brake interlock high during alarm");
  a_brake_soff: assert property (!remote_in.servo_on_cmd ##3 1 |-> !remote_out.brake_interlock_out)
    else $error("brake interlock high after servo-off");
  a_conn_mirror: assert property (external_io_connector == remote_out)
    else $error("connector differs from fieldbus bits");
  a_flag_stable: assert property ($stable(torque_at_limit) ##1 $stable(torque_at_limit)
    |-> $stable(remote_out.torque_limiting_flag))
    else $error("flag changed without cause");
  a_irq_level: assert property (irq == $past(|(st_reg.irq_sts & st_reg.irq_msk)))
    else $error("irq mismatch");
  a_wait_bounded: assert property (bus_req |-> ##[0:2] !avs_waitrequest)
    else $error("waitrequest stuck");

  c_home_valid: cover property (st_reg.abs_enable && $rose(remote_out.home_return_done_flag));
  c_alarm_brake: cover property (remote_out.brake_interlock_out ##1 alarm_active ##1 !remote_out.brake_interlock_out);
  c_irq: cover property ($rose(irq));
  c_write_done: cover property (avs_write && !avs_waitrequest);

endmodule

// File: tb/fieldbus_master_model.sv
/*
  Fieldbus master model: drives the remote input bits and keeps the last status word read.
  Assumes the bench hands it the wanted command word on mclk.
*/
`timescale 1ns/10ps
module fieldbus_master_model (
  // Clock
  input wire logic mclk,
  // Command from the bench
  input wire servo_status_pkg::remote_in_t cmd,
  // Link to the device
  input wire servo_status_pkg::status_flags_t remote_out,
  output servo_status_pkg::remote_in_t remote_in,
  output servo_status_pkg::status_flags_t seen_flags
);
  // A cyclic master refreshes its words once a link cycle, so both directions lag one clock
  always_ff @(posedge mclk)
  begin
    remote_in <= cmd;
    seen_flags <= remote_out;
  end
endmodule

// File: tb/tb_servo_remote_status.sv
/*
  Self-checking bench for the servo remote status outputs.
  Assumes one wait cycle or more per bus access and flags a few clocks behind the pin inputs.
*/
`timescale 1ns/10ps
module tb_servo_remote_status;
  logic mclk, rst_n, drive_operable, alarm_active, torque_at_limit, home_busy, irq;
  logic avs_read, avs_write, avs_waitrequest;
  logic [3:0] pls;
  logic signed [23:0] droop_count, remaining_dist;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, lfsr;
  servo_status_pkg::remote_in_t cmd, remote_in;
  servo_status_pkg::status_flags_t remote_out, external_io_connector, seen;
  int n_mismatch, n_compared, i, ca, cb, d, r, rng, rrng;
  logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h1c};
  logic [31:0] rst_val [6] = '{32'h0, 32'h64, 32'h0, 32'h0, 32'h0, 32'h0};

  servo_remote_status uut (.mclk(mclk), .rst_n(rst_n), .remote_in(remote_in), .drive_operable(drive_operable),
    .alarm_active(alarm_active), .droop_count(droop_count), .remaining_dist(remaining_dist),
    .torque_at_limit(torque_at_limit), .home_busy(home_busy), .home_done_pulse(pls[0]),
    .abs_position_erase_alarm(pls[1]), .abs_counter_warning(pls[2]), .gear_change_pulse(pls[3]),
    .remote_out(remote_out), .external_io_connector(external_io_connector), .irq(irq),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  fieldbus_master_model master (.mclk(mclk), .cmd(cmd), .remote_out(remote_out), .remote_in(remote_in),
    .seen_flags(seen));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] fl(input int b);
    return 32'(remote_out[b]);
  endfunction

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Bus master: hold the request until waitrequest is sampled low
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    // No cycle limit here: a slave that never answers is ended by the watchdog
    do
    begin
      @(posedge mclk);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic pulse(input int b);
    @(posedge mclk);
    pls <= 4'(1 << b);
    @(posedge mclk);
    pls <= 4'h0;
    tick(3);
  endtask

  task automatic finish_test;
    $display("counts: compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #(25ns * 20000);
    n_mismatch++;
    finish_test;
  end

  initial
  begin
    rst_n = 1'b0;
    cmd = '0;
    drive_operable = 1'b1;
    {alarm_active, torque_at_limit, home_busy, avs_read, avs_write} = '0;
    {pls, avs_address, avs_writedata} = '0;
    droop_count = 24'sd1000;
    remaining_dist = 24'sd1000;
    lfsr = 32'hbb5d85ea;
    tick(2);
    rst_n <= 1'b1;
    check(32'(remote_out), 32'h0); // idle levels
    for (i = 0; i < 6; i++)
    begin
      bus(1'b0, ofs[i], 32'h0);
      check(rd, rst_val[i]); // reset values
    end
    $display("test reset done");
    // Servo-on forces in-position and rough match for exactly one cycle
    @(posedge mclk);
    cmd <= 6'h33;
    ca = 0;
    cb = 0;
    for (i = 0; i < 10; i++)
    begin
      @(posedge mclk);
      ca += int'(remote_out.in_position_flag);
      cb += int'(remote_out.rough_match_flag);
    end
    check(ca, 1); // one pulse
    check(cb, 1); // one pulse
    check(fl(0), 1); // ready up
    check(fl(5), 1); // brake released
    check(32'(external_io_connector), 32'(remote_out)); // pin copy
    check(32'(seen), 32'(remote_out)); // fieldbus copy
    // Ready must follow the drive's ability to run, not servo-on alone
    drive_operable <= 1'b0;
    tick(3);
    check(fl(0), 32'h0); // not operable
    drive_operable <= 1'b1;
    tick(3);
    check(fl(0), 32'h1); // operable again
    $display("test servo_on done");
    // Random ranges, first two at the boundaries
    rng = int'(nxt(lfsr) & 32'h3ff);
    rrng = int'(nxt(nxt(lfsr)) & 32'h3ff);
    bus(1'b1, servo_status_pkg::INPOS_RANGE_OFS, 32'(rng));
    bus(1'b1, servo_status_pkg::ROUGH_RANGE_OFS, 32'(rrng));
    for (i = 0; i < 24; i++)
    begin
      lfsr = nxt(lfsr);
      d = (i == 0) ? rng : (i == 1) ? -rng - 1 : int'(lfsr[11:0]) - 2048;
      r = (i == 0) ? rrng : (i == 1) ? 1 - rrng : int'(lfsr[23:12]) - 2048;
      @(posedge mclk);
      droop_count <= 24'(d);
      remaining_dist <= 24'(r);
      torque_at_limit <= lfsr[24];
      tick(3);
      check(fl(1), 32'(((d < 0) ? -d : d) <= rng)); // window
      check(fl(2), 32'(((r < 0) ? -r : r) < rrng)); // window
      check(fl(4), 32'(lfsr[24])); // torque level
      check(32'(external_io_connector), 32'(remote_out)); // pin copy
    end
    $display("test ranges done");
    // Home return completion with and without absolute detection
    pulse(0);
    check(fl(3), 1); // set on done
    bus(1'b1, servo_status_pkg::CTRL_OFS, 32'h1);
    tick(2);
    check(fl(3), 0); // abs enable
    pulse(0);
    check(fl(3), 32'h1); // follows ready
    for (i = 0; i < 6; i++)
    begin
      @(posedge mclk);
      cmd <= 6'h33 ^ 6'(1 << i);
      tick(6);
      check(fl(3), 0); // clear cases
      if (i == 5)
        check(fl(5), 0); // servo off
      @(posedge mclk);
      cmd <= 6'h33;
      tick(8);
      check(fl(3), 1); // follows ready
    end
    @(posedge mclk);
    alarm_active <= 1'b1;
    tick(3);
    check(fl(5), 0); // base still on
    check(fl(3), 0); // alarm
    alarm_active <= 1'b0;
    home_busy <= 1'b1;
    tick(3);
    check(fl(3), 0); // while homing
    home_busy <= 1'b0;
    // Re-home so that every invalidating pulse below meets a valid return
    pulse(0);
    check(fl(3), 32'h1); // done after homing
    for (i = 1; i < 4; i++)
    begin
      pulse(i);
      check(fl(3), 0); // invalidated
      pulse(0);
      check(fl(3), 1); // homed again
    end
    bus(1'b1, servo_status_pkg::CTRL_OFS, 32'h3);
    tick(2);
    check(fl(3), 0); // direction change
    $display("test home done");
    // Interrupt: sticky, masked, write-one-to-clear
    torque_at_limit <= 1'b0;
    tick(2);
    bus(1'b1, servo_status_pkg::IRQ_STATUS_OFS, 32'h3f);
    bus(1'b1, servo_status_pkg::IRQ_MASK_OFS, 32'h10);
    torque_at_limit <= 1'b1;
    tick(3);
    check(32'(irq), 1); // torque event raises irq
    bus(1'b1, servo_status_pkg::IRQ_STATUS_OFS, 32'h10);
    tick(2);
    check(32'(irq), 0); // cleared by write one
    bus(1'b0, servo_status_pkg::IRQ_STATUS_OFS, 32'h0);
    check(rd, 32'h0); // status cleared
    bus(1'b1, servo_status_pkg::IRQ_MASK_OFS, 32'h0);
    torque_at_limit <= 1'b0;
    tick(2);
    torque_at_limit <= 1'b1;
    tick(3);
    check(32'(irq), 0); // masked event
    bus(1'b0, servo_status_pkg::IRQ_STATUS_OFS, 32'h0);
    check(rd, 32'h10); // sticky while masked
    bus(1'b1, 8'h1c, 32'hffffffff);
    bus(1'b0, 8'h1c, 32'h0);
    check(rd, 32'h0); // unmapped reads zero
    $display("test irq done");
    finish_test;
  end
endmodule
